// ### qdis_slave.sv
`timescale 1ns/1ps
// Functional notes
// - identification byte upper nibble must be 1010
// - next three bits match address-select pins
// - lowest id bit: 1 read, 0 write
// - write: start, id, address, data, stop
// - volatile write idles; non-volatile starts programming
// - programming ignores bus, data line released
// - write-protect low: data not acked, idle
// - address 0-3 or 8 loads on LSB fall
// - stop launches programming for 0-6, control zero
// - control byte picks volatile/non-volatile write target
// - read: write id, address, restart, read id
// - send bytes while master acknowledges
// - pointer starts at address, increments per byte
// - pointer wraps from 08h to 00h
// - control byte picks volatile/non-volatile read source
// - change needs valid bytes, exact pulses; stop
// - 80h: wiper only; 00h: wiper and initial
// - 0-3 pots, 4-6 general, 7 reserved
// - start ignored at power-up and programming
// - wipers 80h, then loaded from initial values
module qdis_slave #(
   parameter int WC_TIME_NS = 10000,
   parameter int BOOT_TIME_NS = 200
) (
   // system
   input wire logic clock,
   input wire logic sys_rst,
   // serial link
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // straps and protection
   input wire logic addr_select_pin_hi,
   input wire logic addr_select_pin_mid,
   input wire logic addr_select_pin_lo,
   input wire logic wp_n,
   // potentiometer side
   output qdis_pkg::qdis_wipers_t wiper,
   output qdis_pkg::qdis_status_t status
);
   import qdis_pkg::*;
   localparam int WC_CYC = (WC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BOOT_CYC =
      (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TW = $clog2(WC_CYC + BOOT_CYC + 1);
   // link domain: bit sampled on each scl rise, announced by a toggle
   logic link_tog, link_bit, next_link_tog, wp_ok;
   always_comb next_link_tog = ~link_tog;
   always_ff @(posedge scl or posedge sys_rst) begin
      if (sys_rst) begin
         link_tog <= 1'b0;
         link_bit <= 1'b0;
      end else begin
         link_tog <= next_link_tog;
         link_bit <= sda_i;
      end
   end
   logic [1:0] scl_s, sda_s, wp_s, tog_s;
   logic [2:0] pin_s1, pin_s2;
   logic scl_d, sda_d, tog_d, scl_hi, start_ev, stop_ev, rise_ev, fall_ev;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         wp_s <= 2'h0;
         tog_s <= 2'h0;
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         tog_d <= 1'b0;
      end else begin
         scl_s <= {scl_s[0], scl};
         sda_s <= {sda_s[0], sda_i};
         wp_s <= {wp_s[0], wp_n};
         tog_s <= {tog_s[0], link_tog};
         pin_s1 <= {addr_select_pin_hi, addr_select_pin_mid,
                    addr_select_pin_lo};
         pin_s2 <= pin_s1;
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
         tog_d <= tog_s[1];
      end
   end
   always_comb begin
      scl_hi = scl_s[1] & scl_d;
      start_ev = scl_hi & sda_d & ~sda_s[1];
      stop_ev = scl_hi & ~sda_d & sda_s[1];
      rise_ev = tog_s[1] ^ tog_d;
      fall_ev = scl_d & ~scl_s[1];
      wp_ok = wp_s[1];
   end
   qdis_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shreg, next_shreg, addr, next_addr, ptr, next_ptr;
   logic [7:0] acr, next_acr, tx, next_tx;
   logic rd, next_rd, pend, next_pend, next_oe;
   logic [TW-1:0] timer, next_timer;
   qdis_wipers_t next_wiper;
   qdis_status_t next_status;
   logic [7:0] nv [NV_DEPTH], next_nv [NV_DEPTH];
   function automatic logic id_match(input logic [7:0] b,
                                     input logic [2:0] pins);
      id_match = (b[7:4] == ID_PREFIX) && (b[3:1] == pins);
   endfunction
   // volatile view only for pots in 80h mode; reserved byte reads raw
   function automatic logic [7:0] read_byte(input logic [7:0] p);
      if (p < POT_COUNT)
         read_byte = (acr == ACR_VOL) ? wiper[p[1:0]] : nv[p[2:0]];
      else if (p <= ADDR_RSVD)
         read_byte = nv[p[2:0]];
      else if (p == ADDR_ACR)
         read_byte = acr;
      else
         read_byte = BYTE_ZERO;
   endfunction
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shreg = shreg;
      next_addr = addr;
      next_ptr = ptr;
      next_acr = acr;
      next_tx = tx;
      next_rd = rd;
      next_pend = pend;
      next_oe = sda_oe;
      next_timer = timer;
      next_wiper = wiper;
      next_nv = nv;
      case (state)
         ST_BOOT: begin
            next_oe = 1'b0;
            if (timer == TW'(BOOT_CYC - 1)) begin
               for (int i = 0; i < 4; i++) next_wiper[i] = nv[i];
               next_timer = '0;
               next_state = ST_IDLE;
            end else
               next_timer = timer + 1'b1;
         end
         ST_BUSY: begin
            next_oe = 1'b0;
            if (timer == TW'(WC_CYC - 1)) begin
               next_timer = '0;
               next_state = ST_IDLE;
            end else
               next_timer = timer + 1'b1;
         end
         default: begin
            if (stop_ev) begin
               next_oe = 1'b0;
               next_cnt = '0;
               next_pend = 1'b0;
               if (state == ST_WDONE && pend) begin
                  next_nv[addr[2:0]] = shreg;
                  next_state = ST_BUSY;
               end else
                  next_state = ST_IDLE;
            end else if (start_ev) begin
               next_oe = 1'b0;
               next_cnt = '0;
               next_pend = 1'b0;
               next_state = ST_ID;
            end else begin
               case (state)
                  ST_ID, ST_ADDR, ST_WDATA: begin
                     if (rise_ev && cnt < BYTE_BITS) begin
                        next_shreg = {shreg[6:0], link_bit};
                        next_cnt = cnt + 1'b1;
                     end
                     if (fall_ev && cnt == BYTE_BITS) begin
                        next_cnt = '0;
                        if (state == ST_ID) begin
                           if (id_match(shreg, pin_s2)) begin
                              next_rd = shreg[0];
                              next_oe = 1'b1;
                              next_state = ST_ACK_ID;
                           end else
                              next_state = ST_IDLE;
                        end else if (state == ST_ADDR) begin
                           next_addr = shreg;
                           next_ptr = shreg;
                           next_oe = 1'b1;
                           next_state = ST_ACK_ADDR;
                        end else if (!wp_ok)
                           next_state = ST_IDLE;
                        else begin
                           next_oe = 1'b1;
                           next_state = ST_ACK_DATA;
                           if (addr < POT_COUNT)
                              next_wiper[addr[1:0]] = shreg;
                           if (addr == ADDR_ACR)
                              next_acr = shreg;
                           next_pend = (acr == ACR_NV) &&
                                       (addr <= ADDR_NV_LAST);
                        end
                     end
                  end
                  ST_ACK_ID, ST_ACK_ADDR, ST_ACK_DATA: begin
                     if (fall_ev) begin
                        next_oe = 1'b0;
                        if (state == ST_ACK_ADDR)
                           next_state = ST_WDATA;
                        else if (state == ST_ACK_DATA)
                           next_state = ST_WDONE;
                        else if (!rd)
                           next_state = ST_ADDR;
                        else begin
                           next_tx = read_byte(ptr);
                           next_oe = ~next_tx[7];
                           next_state = ST_RDATA;
                        end
                     end
                  end
                  ST_RDATA: begin
                     if (rise_ev) next_cnt = cnt + 1'b1;
                     if (fall_ev && cnt == BYTE_BITS) begin
                        next_oe = 1'b0;
                        next_cnt = '0;
                        next_ptr = (ptr == ADDR_ACR) ? BYTE_ZERO
                                 : 8'(ptr + 1'b1);
                        next_state = ST_RACK;
                     end else if (fall_ev && cnt != 4'h0) begin
                        next_tx = {tx[6:0], 1'b0};
                        next_oe = ~tx[6];
                     end
                  end
                  ST_RACK: begin
                     if (rise_ev) next_shreg[0] = link_bit;
                     if (fall_ev && cnt == 4'h0 && !rise_ev) begin
                        if (!shreg[0]) begin
                           next_tx = read_byte(ptr);
                           next_oe = ~next_tx[7];
                           next_state = ST_RDATA;
                        end else
                           next_state = ST_IDLE;
                     end
                  end
                  ST_WDONE: begin
                     // only a whole extra pulse (a fall) voids it
                     if (fall_ev) begin
                        next_pend = 1'b0;
                        next_state = ST_IDLE;
                     end
                  end
                  default: ;
               endcase
            end
         end
      endcase
      next_status.booting = (next_state == ST_BOOT);
      next_status.nv_busy = (next_state == ST_BUSY);
      next_status.vol_mode = (next_acr == ACR_VOL);
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= ST_BOOT;
         cnt <= '0;
         shreg <= BYTE_ZERO;
         addr <= BYTE_ZERO;
         ptr <= BYTE_ZERO;
         acr <= ACR_NV;
         tx <= BYTE_ZERO;
         rd <= 1'b0;
         pend <= 1'b0;
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
         timer <= '0;
         wiper <= {4{WIPER_RESET}};
         status <= 3'h4;
         // power-up stands in for the factory contents of the array
         for (int i = 0; i < NV_DEPTH; i++)
            nv[i] <= (i < 4) ? IVR_INIT : GP_INIT;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         shreg <= next_shreg;
         addr <= next_addr;
         ptr <= next_ptr;
         acr <= next_acr;
         tx <= next_tx;
         rd <= next_rd;
         pend <= next_pend;
         sda_oe <= next_oe;
         sda_o <= 1'b0;
         timer <= next_timer;
         wiper <= next_wiper;
         status <= next_status;
         nv <= next_nv;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   busy_quiet_a: assert property (
      state == ST_BUSY |-> !sda_oe) else $error("drive while busy");
   busy_hold_a: assert property (
      state == ST_BUSY && timer < TW'(WC_CYC - 1) |=> state == ST_BUSY)
      else $error("programming ended early");
   start_ign_a: assert property (
      (state == ST_BUSY || state == ST_BOOT) && start_ev
      |=> state != ST_ID) else $error("start taken while busy");
   id_nack_a: assert property (
      state == ST_ID && fall_ev && cnt == BYTE_BITS &&
      !id_match(shreg, pin_s2) |=> state == ST_IDLE && !sda_oe)
      else $error("bad id acknowledged");
   id_ack_a: assert property (
      state == ST_ID && fall_ev && cnt == BYTE_BITS &&
      id_match(shreg, pin_s2) |=> sda_oe ##0 state == ST_ACK_ID)
      else $error("good id not acknowledged");
   wp_nack_a: assert property (
      state == ST_WDATA && fall_ev && cnt == BYTE_BITS && !wp_ok
      |=> !sda_oe && state == ST_IDLE) else $error("protected ack");
   wiper_load_a: assert property (
      state == ST_WDATA && fall_ev && cnt == BYTE_BITS && wp_ok &&
      addr < POT_COUNT |=> wiper[addr[1:0]] == shreg)
      else $error("wiper not loaded");
   wiper_only_a: assert property (
      $changed(wiper) |-> $past(state) == ST_WDATA ||
      $past(state) == ST_BOOT) else $error("stray wiper change");
   ptr_wrap_a: assert property (
      state == ST_RDATA && fall_ev && cnt == BYTE_BITS &&
      ptr == ADDR_ACR |=> ptr == BYTE_ZERO) else $error("no wrap");
   nv_start_a: assert property (
      state == ST_WDONE && stop_ev && pend |=> state == ST_BUSY ##1
      state == ST_BUSY) else $error("no programming cycle");
   dir_a: assert property (
      state == ST_ACK_ID && fall_ev |=>
      (rd ? state == ST_RDATA : state == ST_ADDR))
      else $error("wrong direction");
   write_c: cover property (state == ST_ACK_DATA ##[1:300] stop_ev);
   read2_c: cover property (state == ST_RACK ##[1:300] state == ST_RDATA);
   nv_c: cover property (state == ST_BUSY ##1 state == ST_IDLE);
   wp_c: cover property (state == ST_WDATA && fall_ev && !wp_ok);
endmodule

// ### qdis_pkg.sv
package qdis_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam logic [3:0] ID_PREFIX = 4'ha;
   localparam logic [7:0] ADDR_ACR = 8'h08;
   localparam logic [7:0] ADDR_NV_LAST = 8'h06;
   localparam logic [7:0] ADDR_RSVD = 8'h07;
   localparam logic [7:0] POT_COUNT = 8'h04;
   localparam logic [7:0] ACR_VOL = 8'h80;
   localparam logic [7:0] ACR_NV = 8'h00;
   localparam logic [7:0] WIPER_RESET = 8'h80;
   localparam logic [7:0] IVR_INIT = 8'h80;
   localparam logic [7:0] GP_INIT = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int NV_DEPTH = 8;

   typedef logic [3:0][7:0] qdis_wipers_t;

   typedef struct packed {
      logic booting;
      logic nv_busy;
      logic vol_mode;
   } qdis_status_t;

   typedef enum logic [3:0] {
      ST_BOOT, ST_IDLE, ST_ID, ST_ACK_ID, ST_ADDR, ST_ACK_ADDR,
      ST_WDATA, ST_ACK_DATA, ST_WDONE, ST_RDATA, ST_RACK, ST_BUSY
   } qdis_state_t;
endpackage

// ### qdis_master.sv
`timescale 1ns/1ps
module qdis_master (
   // serial link
   output logic scl,
   output logic sda_oe,
   input wire logic sda
);
   // quarter of the 125 ns bit; scl rests high between frames
   localparam realtime Q = 31.25;

   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   // data changes only while scl is low; sampled mid high phase
   task automatic bit_xfer(input logic b, output logic got);
      sda_oe = ~b;
      #Q scl = 1'b1;
      #Q got = sda;
      #Q scl = 1'b0;
      #Q;
   endtask

   // also serves as repeated start after an ack bit
   task automatic send_start();
      sda_oe = 1'b0;
      #Q scl = 1'b1;
      #Q sda_oe = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask

   task automatic send_stop();
      sda_oe = 1'b1;
      #Q scl = 1'b1;
      #Q sda_oe = 1'b0;
      #Q;
   endtask

   // returns 1 when the slave pulled the ack low
   task automatic put_byte(input logic [7:0] d, output logic acked);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], g);
      end
      bit_xfer(1'b1, g);
      acked = ~g;
   endtask

   task automatic get_byte(input logic more, output logic [7:0] d);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, g);
         d[i] = g;
      end
      bit_xfer(~more, g);
   endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
   import qdis_pkg::*;
   logic clock, sys_rst, wp_n, m_oe, scl, sda_o, sda_oe;
   logic [2:0] pins;
   wire sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
   qdis_wipers_t wiper;
   qdis_status_t status;
   int fail_count = 0;
   int comparisons = 0;
   logic [7:0] ew [4] = '{8'h80, 8'h80, 8'h80, 8'h80};
   logic [7:0] env [8] = '{8'h80, 8'h80, 8'h80, 8'h80,
      8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] acr = 8'h00;
   // address, data, wiper expected after the write
   logic [23:0] rows [4] = '{24'h001111, 24'h012222, 24'h023333,
      24'h034444};

   qdis_slave #(.WC_TIME_NS(200), .BOOT_TIME_NS(40)) qdis_slave_inst (
      .clock(clock), .sys_rst(sys_rst), .scl(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin_hi(pins[2]),
      .addr_select_pin_mid(pins[1]), .addr_select_pin_lo(pins[0]),
      .wp_n(wp_n), .wiper(wiper), .status(status));
   qdis_master qdis_master_inst (.scl(scl), .sda_oe(m_oe), .sda(sda));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic tally_and_finish();
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_flag(input logic which);
      int n;
      n = 0;
      while ((which ? status.nv_busy : status.booting) !== 1'b0
             && n < 400) begin
         @(posedge clock);
         n++;
      end
      if (n >= 400) begin
         fail_count++;
         $display("[ERR] %0t wait ran out", $time);
         tally_and_finish();
      end
   endtask

   function automatic logic [7:0] exp_at(input logic [7:0] p);
      if (p < POT_COUNT) return (acr == ACR_VOL) ? ew[p[1:0]] : env[p[2:0]];
      if (p < ADDR_ACR) return env[p[2:0]];
      return (p == ADDR_ACR) ? acr : BYTE_ZERO;
   endfunction

   task automatic id_try(input logic [7:0] id, input logic exp);
      logic ak;
      qdis_master_inst.send_start();
      qdis_master_inst.put_byte(id, ak);
      qdis_master_inst.send_stop();
      check(ak, exp);
   endtask

   // extra adds one scl pulse before the stop
   task automatic wreg(input logic [7:0] a, d, input logic extra);
      logic ak, nvw;
      nvw = wp_n && a <= ADDR_NV_LAST && acr == ACR_NV && !extra;
      qdis_master_inst.send_start();
      qdis_master_inst.put_byte({ID_PREFIX, pins, 1'b0}, ak);
      check(ak, 1'b1);
      qdis_master_inst.put_byte(a, ak);
      check(ak, 1'b1);
      qdis_master_inst.put_byte(d, ak);
      check(ak, wp_n);
      if (extra) begin
         qdis_master_inst.bit_xfer(1'b1, ak);
      end
      qdis_master_inst.send_stop();
      check(status.nv_busy, nvw);
      if (wp_n && a < POT_COUNT) ew[a[1:0]] = d;
      if (wp_n && a == ADDR_ACR) acr = d;
      if (nvw) env[a[2:0]] = d;
   endtask

   task automatic rd(input logic [7:0] a, input int n);
      logic ak;
      logic [7:0] d, p;
      p = a;
      qdis_master_inst.send_start();
      qdis_master_inst.put_byte({ID_PREFIX, pins, 1'b0}, ak);
      check(ak, 1'b1);
      qdis_master_inst.put_byte(a, ak);
      check(ak, 1'b1);
      qdis_master_inst.send_start();
      qdis_master_inst.put_byte({ID_PREFIX, pins, 1'b1}, ak);
      check(ak, 1'b1);
      for (int k = 0; k < n; k++) begin
         qdis_master_inst.get_byte(k != n - 1, d);
         check(d, exp_at(p));
         p = (p == ADDR_ACR) ? 8'h00 : p + 8'h01;
      end
      qdis_master_inst.send_stop();
   endtask

   initial begin
      sys_rst = 1'b1;
      wp_n = 1'b1;
      pins = 3'h5;
      repeat (6) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         check(wiper[i], WIPER_RESET);
      end
      check(status.booting, 1'b1);
      #1 sys_rst = 1'b0;
      wait_flag(1'b0);
      for (int i = 0; i < 4; i++) begin
         check(wiper[i], IVR_INIT);
      end
      foreach (rows[r]) begin
         wreg(rows[r][23:16], rows[r][15:8], 1'b0);
         check(wiper[rows[r][17:16]], rows[r][7:0]);
         wait_flag(1'b1);
      end
      rd(8'h00, 11);
      id_try({ID_PREFIX, ~pins, 1'b0}, 1'b0);
      id_try({4'hb, pins, 1'b0}, 1'b0);
      @(posedge clock) #1 wp_n = 1'b0;
      repeat (4) @(posedge clock);
      wreg(8'h02, 8'h5a, 1'b0);
      check(wiper[2], 8'h33);
      @(posedge clock) #1 wp_n = 1'b1;
      repeat (4) @(posedge clock);
      wreg(8'h05, 8'hc3, 1'b0);
      check(sda_oe, 1'b0);
      id_try({ID_PREFIX, pins, 1'b0}, 1'b0);
      wait_flag(1'b1);
      id_try({ID_PREFIX, pins, 1'b0}, 1'b1);
      wreg(ADDR_ACR, ACR_VOL, 1'b0);
      check(status.vol_mode, 1'b1);
      wreg(8'h00, 8'h99, 1'b0);
      check(wiper[0], 8'h99);
      rd(8'h00, 1);
      wreg(ADDR_ACR, ACR_NV, 1'b0);
      rd(8'h00, 1);
      wreg(8'h01, 8'h77, 1'b1);
      check(wiper[1], 8'h77);
      rd(8'h01, 1);
      // mid-run reset: wipers drop to mid-scale, recall runs again
      @(posedge clock) #1 sys_rst = 1'b1;
      repeat (6) @(posedge clock);
      check(wiper[1], WIPER_RESET);
      check(status.booting, 1'b1);
      #1 sys_rst = 1'b0;
      wait_flag(1'b0);
      check(wiper[0], IVR_INIT);
      @(posedge clock) #1 pins = 3'h2;
      repeat (4) @(posedge clock);
      id_try({ID_PREFIX, 3'h2, 1'b0}, 1'b1);
      tally_and_finish();
   end
endmodule
